// ### rtl/dwpr_map.vh
/*
 * Register map and constants of the display writeback pipe reuse block.
 * Assumes a 32-bit AXI4-Lite slave with word-aligned byte addresses.
 */
`ifndef DWPR_MAP_VH
`define DWPR_MAP_VH

`define DWPR_OFF_CAPTURE   12'h000
`define DWPR_OFF_VID0      12'h004
`define DWPR_OFF_VID1      12'h008
`define DWPR_OFF_VID2      12'h00c
`define DWPR_OFF_STATUS    12'h010
`define DWPR_OFF_SYNCLOST  12'h014

`define DWPR_BIT_ENABLE    0
`define DWPR_BIT_MODE      19
`define DWPR_POS_ROUTE     1
`define DWPR_ROUTE_W       2
`define DWPR_ROUTE_PANEL   2'h0
`define DWPR_ROUTE_CAPTURE 2'h1

`define DWPR_RESP_OKAY     2'h0
`define DWPR_RESP_SLVERR   2'h2
`define DWPR_ZERO32        32'h00000000

`endif

// ### rtl/dwpr_top.v
/*
 * Video pipe and memory capture path control: three video pipes, each
 * routable to a panel or to the capture-to-memory path, with an AXI4-Lite
 * register slave.  Assumes panel frame start and copy-done strobes come
 * from another clock domain and are synchronised here.
 */
// Function
// - Bit 19 of the capture attributes selects memory-to-memory operation.
// - At copy completion in memory-to-memory mode the capture enable clears itself; pipe enables stay.
// - A still-enabled pipe rerouted to a live panel connects mid-frame and raises sync lost.
// - Three video pipes exist, each with an enable in bit 0, any routable to capture.
`timescale 1ns/1ps
`include "dwpr_map.vh"

module dwpr_top
(
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        panel_frame_start,
    input  wire        copy_done,
    output reg  [2:0]  pipe_to_panel,
    output reg  [2:0]  pipe_to_capture,
    output reg         sync_lost
);

    reg  [1:0]  fs_sync_reg;
    reg  [1:0]  cd_sync_reg;
    reg         fs_prev_reg;
    reg         cd_prev_reg;
    wire        fs_pulse;
    wire        cd_pulse;

    reg         cap_en_reg;
    reg         cap_mode_reg;
    reg  [2:0]  vid_en_reg;
    reg  [5:0]  vid_route_reg;
    reg         sync_lost_reg;

    reg  [11:0] aw_addr_reg;
    reg         aw_have_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_have_reg;
    wire        do_write;
    reg  [31:0] rd_value;
    reg         rd_hit;

    reg  [2:0]  new_en;
    reg  [5:0]  new_route;
    reg         new_cap_en;
    reg         new_cap_mode;
    reg         new_lost;
    reg  [2:0]  panel_next;
    reg  [2:0]  cap_next;
    reg  [1:0]  old_rt;
    reg  [1:0]  nrt;
    reg  [2:0]  live_rr;
    reg  [1:0]  rt_now;
    integer     i;
    integer     k;

    // Two-stage synchronisers; only the second stage is read
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fs_sync_reg <= 2'h0;
            cd_sync_reg <= 2'h0;
            fs_prev_reg <= 1'b0;
            cd_prev_reg <= 1'b0;
        end
        else
        begin
            fs_sync_reg <= {fs_sync_reg[0], panel_frame_start};
            cd_sync_reg <= {cd_sync_reg[0], copy_done};
            fs_prev_reg <= fs_sync_reg[1];
            cd_prev_reg <= cd_sync_reg[1];
        end
    end

    assign fs_pulse = fs_sync_reg[1] & ~fs_prev_reg;
    assign cd_pulse = cd_sync_reg[1] & ~cd_prev_reg;

    assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;

    // Register state update: software writes, then hardware events
    always @*
    begin
        new_en       = vid_en_reg;
        new_route    = vid_route_reg;
        new_cap_en   = cap_en_reg;
        new_cap_mode = cap_mode_reg;
        new_lost     = sync_lost_reg;
        live_rr      = 3'h0;
        old_rt       = 2'h0;
        nrt          = 2'h0;
        i            = 0;
        if (do_write && w_strb_reg[0])
        begin
            case (aw_addr_reg)
                `DWPR_OFF_CAPTURE:
                    new_cap_en = w_data_reg[`DWPR_BIT_ENABLE];
                `DWPR_OFF_VID0, `DWPR_OFF_VID1, `DWPR_OFF_VID2:
                begin
                    i = (aw_addr_reg - `DWPR_OFF_VID0) >> 2;
                    new_en[i] = w_data_reg[`DWPR_BIT_ENABLE];
                    new_route[2*i +: 2] =
                        w_data_reg[`DWPR_POS_ROUTE +: `DWPR_ROUTE_W];
                end
                // Write one to clear; a same-cycle event below wins
                `DWPR_OFF_SYNCLOST:
                    if (w_data_reg[0])
                        new_lost = 1'b0;
                default:
                    new_lost = new_lost;
            endcase
        end
        if (do_write && w_strb_reg[2] &&
            aw_addr_reg == `DWPR_OFF_CAPTURE)
            new_cap_mode = w_data_reg[`DWPR_BIT_MODE];
        // Copy done clears only the capture enable
        if (cd_pulse && cap_en_reg && cap_mode_reg)
            new_cap_en = 1'b0;
        // Live reroute of an enabled pipe to the panel loses sync
        for (i = 0; i < 3; i = i + 1)
        begin
            old_rt = vid_route_reg[2*i +: 2];
            nrt    = new_route[2*i +: 2];
            if (vid_en_reg[i] && new_en[i] &&
                old_rt != `DWPR_ROUTE_PANEL && nrt == `DWPR_ROUTE_PANEL)
            begin
                new_lost   = 1'b1;
                live_rr[i] = 1'b1;
            end
        end
    end

    // Output routing of each pipe, taken from the values being loaded
    // so that capture outputs, panel disconnects and live reroutes change on the same edge as enable and route
    always @*
    begin
        panel_next = pipe_to_panel;
        cap_next   = 3'h0;
        rt_now     = 2'h0;
        for (k = 0; k < 3; k = k + 1)
        begin
            rt_now = new_route[2*k +: 2];
            cap_next[k] = new_en[k] & new_cap_en &
                          (rt_now == `DWPR_ROUTE_CAPTURE);
            if (!new_en[k] || rt_now != `DWPR_ROUTE_PANEL)
                panel_next[k] = 1'b0;
            // Live reroute connects at once, mid-frame
            else if (live_rr[k])
                panel_next[k] = 1'b1;
            // Otherwise output waits for the next frame start
            else if (fs_pulse)
                panel_next[k] = 1'b1;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cap_en_reg      <= 1'b0;
            cap_mode_reg    <= 1'b0;
            vid_en_reg      <= 3'h0;
            vid_route_reg   <= 6'h00;
            sync_lost_reg   <= 1'b0;
            pipe_to_panel   <= 3'h0;
            pipe_to_capture <= 3'h0;
            sync_lost       <= 1'b0;
        end
        else
        begin
            cap_en_reg      <= new_cap_en;
            cap_mode_reg    <= new_cap_mode;
            vid_en_reg      <= new_en;
            vid_route_reg   <= new_route;
            sync_lost_reg   <= new_lost;
            pipe_to_panel   <= panel_next;
            pipe_to_capture <= cap_next;
            sync_lost       <= new_lost;
        end
    end

    // AXI4-Lite write channel: address and data taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 12'h000;
            w_data_reg    <= `DWPR_ZERO32;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DWPR_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_have_reg & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= ~w_have_reg & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg <= `DWPR_OFF_SYNCLOST) ?
                                `DWPR_RESP_OKAY : `DWPR_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode
    always @*
    begin
        rd_value = `DWPR_ZERO32;
        rd_hit   = 1'b1;
        case ({s_axi_araddr[11:2], 2'h0})
            `DWPR_OFF_CAPTURE:
            begin
                rd_value[`DWPR_BIT_ENABLE] = cap_en_reg;
                rd_value[`DWPR_BIT_MODE]   = cap_mode_reg;
            end
            `DWPR_OFF_VID0:
                rd_value[2:0] = {vid_route_reg[1:0], vid_en_reg[0]};
            `DWPR_OFF_VID1:
                rd_value[2:0] = {vid_route_reg[3:2], vid_en_reg[1]};
            `DWPR_OFF_VID2:
                rd_value[2:0] = {vid_route_reg[5:4], vid_en_reg[2]};
            `DWPR_OFF_STATUS:
                rd_value[5:0] = {pipe_to_capture, pipe_to_panel};
            `DWPR_OFF_SYNCLOST:
                rd_value[0] = sync_lost_reg;
            default:
                rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `DWPR_ZERO32;
            s_axi_rresp   <= `DWPR_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_value;
                s_axi_rresp  <= rd_hit ? `DWPR_RESP_OKAY
                                       : `DWPR_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ### test/dwpr_panel_model.sv
/* Panel timing and copy engine seen from the pipe control block.
   Assumes copy_req is pulsed by the bench. */
`timescale 1ns/1ps
module dwpr_panel_model
#(
    parameter int FRAME = 64
)
(
    input  wire logic aclk,
    input  wire logic copy_req,
    output wire logic panel_frame_start,
    output logic      copy_done
);
    int n = 0;
    initial copy_done = 1'b0;
    // Frame start held four cycles so the slow sync catches it
    assign panel_frame_start = (n < 4);
    always @(posedge aclk)
        n <= (n == FRAME - 1) ? 0 : n + 1;
    always @(posedge copy_req)
    begin
        copy_done <= 1'b1;
        repeat (4) @(posedge aclk);
        copy_done <= 1'b0;
    end
endmodule

// ### test/dwpr_top_chk.sv
/* Port checker for dwpr_top.
   Assumes one aclk domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module dwpr_chk
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        panel_frame_start,
    input wire logic [2:0]  pipe_to_panel,
    input wire logic [2:0]  pipe_to_capture,
    input wire logic        sync_lost
);
    logic [3:0] fs_age;
    // Cycles since the panel frame start was last high
    always @(posedge aclk)
        if (!aresetn || panel_frame_start)
            fs_age <= 4'h0;
        else if (fs_age != 4'hf)
            fs_age <= fs_age + 4'h1;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bhold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    bonce_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    rhold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    ranswer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    route_excl_a: assert property (
        (pipe_to_panel & pipe_to_capture) == 3'h0)
        else $error("pipe on panel and capture");
    lost_cause_a: assert property (
        $rose(sync_lost) |->
        (pipe_to_panel & ~$past(pipe_to_panel)) != 3'h0)
        else $error("sync lost without reroute");
    aligned_a: assert property (
        (pipe_to_panel & ~$past(pipe_to_panel)) != 3'h0 &&
        !$rose(sync_lost) |-> fs_age <= 4'h6)
        else $error("panel output not frame aligned");
    lost_clear_a: assert property (
        $fell(sync_lost) && $past(aresetn) |-> $past(s_axi_wvalid) ||
        $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("sync lost cleared without write");
    cover property ($rose(sync_lost));
    cover property ((pipe_to_panel & ~$past(pipe_to_panel)) != 3'h0);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind dwpr_top dwpr_chk u_chk (.*);

// ### test/dwpr_top_bench.sv
/* Register-level bench for dwpr_top.
   Assumes the panel model supplies frame starts and copy completion. */
`timescale 1ns/1ps
`include "dwpr_map.vh"
module dwpr_top_bench;
    logic        aclk = 0, aresetn = 0, copy_req = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, sync_lost;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [2:0]  pipe_to_panel, pipe_to_capture;
    wire         panel_frame_start, copy_done;
    int          n_fail = 0, checks_done = 0, cyc = 0;
    dwpr_top u_dut (.*);
    dwpr_panel_model u_panel (.*);
    initial forever #4 aclk = ~aclk;
    task automatic tick(int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        bit ah = 0, dh = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ah && dh))
        begin
            @(posedge aclk);
            if (!ah && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (!dh && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            ah |= s_axi_awready;
            dh |= s_axi_wready;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
        rd(a);
        cmp(nm, e, rv);
    endtask
    task automatic copy;
        copy_req <= 1'b1;
        tick(1);
        copy_req <= 1'b0;
        tick(10);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            results;
        end
    end
    initial
    begin
        tick(8);
        aresetn <= 1'b1;
        rdc("status", `DWPR_OFF_STATUS, 32'h0);
        s_axi_wstrb <= 4'h0;
        wr(`DWPR_OFF_VID0, 32'h3);
        s_axi_wstrb <= 4'hf;
        rdc("no_strb", `DWPR_OFF_VID0, 32'h0);
        wr(12'h018, 32'h1);
        cmp("bresp", `DWPR_RESP_SLVERR, rs);
        rd(12'h020);
        cmp("rresp", `DWPR_RESP_SLVERR, rs);
        wr(`DWPR_OFF_CAPTURE, 32'h00080001);
        rdc("mode", `DWPR_OFF_CAPTURE, 32'h00080001);
        for (int i = 0; i < 3; i++)
        begin
            wr(`DWPR_OFF_VID0 + 12'(4 * i), 32'h3);
            tick(3);
            cmp("capture", 32'(1 << i), 32'(pipe_to_capture));
            rdc("status_cap", `DWPR_OFF_STATUS, 32'(8 << i));
            wr(`DWPR_OFF_VID0 + 12'(4 * i), 32'h0);
        end
        wr(`DWPR_OFF_VID1, 32'h3);
        copy;
        rdc("cap_done", `DWPR_OFF_CAPTURE, 32'h00080000);
        rdc("pipe_kept", `DWPR_OFF_VID1, 32'h3);
        wr(`DWPR_OFF_VID1, 32'h1);
        tick(3);
        cmp("lost", 32'h1, 32'(sync_lost));
        cmp("panel", 32'h2, 32'(pipe_to_panel));
        rdc("status_lost", `DWPR_OFF_STATUS, 32'h2);
        rdc("lost_reg", `DWPR_OFF_SYNCLOST, 32'h1);
        wr(`DWPR_OFF_SYNCLOST, 32'h1);
        rdc("lost_clr", `DWPR_OFF_SYNCLOST, 32'h0);
        wr(`DWPR_OFF_VID1, 32'h0);
        wr(`DWPR_OFF_CAPTURE, 32'h00080001);
        wr(`DWPR_OFF_VID1, 32'h3);
        copy;
        wr(`DWPR_OFF_VID1, 32'h2);
        wr(`DWPR_OFF_CAPTURE, 32'h00080001);
        wr(`DWPR_OFF_CAPTURE, 32'h00080000);
        wr(`DWPR_OFF_VID1, 32'h0);
        @(posedge panel_frame_start);
        tick(10);
        wr(`DWPR_OFF_VID1, 32'h1);
        tick(2);
        cmp("early", 32'h0, 32'(pipe_to_panel));
        @(posedge panel_frame_start);
        tick(8);
        cmp("aligned", 32'h2, 32'(pipe_to_panel));
        cmp("no_lost", 32'h0, 32'(sync_lost));
        results;
    end
endmodule
